/* File: hdl/clk_pkg.sv */
package clk_pkg;
   // ------------------------------------------------------------
   // Register map (byte addresses, one word each)
   // ------------------------------------------------------------
   localparam logic [7:0] CLK_CTRL_OFS = 8'h00;
   localparam logic [7:0] CLK_ADDR_OFS = 8'h04;
   localparam logic [7:0] CLK_DATA_OFS = 8'h08;
   localparam logic [7:0] CLK_CMD_OFS = 8'h0C;
   localparam logic [7:0] CLK_STAT_OFS = 8'h10;
   localparam logic [7:0] CLK_RESULT_OFS = 8'h14;
   // ------------------------------------------------------------
   // Field positions
   // ------------------------------------------------------------
   localparam int CLK_STAT_BUSY_POS = 0;
   localparam int CLK_STAT_REFUSED_POS = 1;
   localparam int CLK_STAT_TBL_BLOCK_POS = 2;
   localparam int CLK_STAT_EA_LATCHED_POS = 3;
   localparam int CLK_STAT_VFY_BLOCK_POS = 4;
   localparam int CLK_STAT_EXT_BLOCK_POS = 5;
   localparam int CLK_STAT_EA_VALUE_POS = 6;
   // ------------------------------------------------------------
   // Sizes and reset values
   // ------------------------------------------------------------
   localparam int CLK_CODE_AW = 14;
   localparam int CLK_CODE_DEPTH = 16384;
   localparam int CLK_ENC_AW = 6;
   localparam int CLK_ENC_DEPTH = 64;
   localparam logic [7:0] CLK_ERASED_BYTE = 8'hFF;
   localparam logic [31:0] CLK_RESET_WORD = 32'h0000_0000;
   localparam logic [31:0] CLK_UNMAPPED_WORD = 32'h0000_0000;
   // Signature locations
   localparam logic [13:0] CLK_SIG_LOC0 = 14'h0030;
   localparam logic [13:0] CLK_SIG_LOC1 = 14'h0031;
   localparam logic [13:0] CLK_SIG_LOC2 = 14'h0060;
   // ------------------------------------------------------------
   // Commands
   // ------------------------------------------------------------
   localparam logic [2:0] CLK_CMD_PROG_CODE = 3'h1;
   localparam logic [2:0] CLK_CMD_VERIFY = 3'h2;
   localparam logic [2:0] CLK_CMD_PROG_ENC = 3'h3;
   localparam logic [2:0] CLK_CMD_PROG_LOCK = 3'h4;
   localparam logic [2:0] CLK_CMD_SIGNATURE = 3'h5;
   localparam logic [2:0] CLK_CMD_ERASE = 3'h6;

   typedef enum logic [3:0] {
      CLK_LVL_NONE = 4'b0001,
      CLK_LVL_ONE = 4'b0010,
      CLK_LVL_TWO = 4'b0100,
      CLK_LVL_THREE = 4'b1000
   } clk_level_e;

   typedef enum logic [2:0] {
      CLK_ST_IDLE = 3'b001,
      CLK_ST_EXEC = 3'b010,
      CLK_ST_ERASE = 3'b100
   } clk_state_e;

   // Lock word from three bits, 1 = unprogrammed
   function automatic clk_level_e clk_decode(input logic [2:0] lb);
      if (lb[0]) begin
         return CLK_LVL_NONE;
      end else if (lb[1]) begin
         return CLK_LVL_ONE;
      end else if (lb[2]) begin
         return CLK_LVL_TWO;
      end else begin
         return CLK_LVL_THREE;
      end
   endfunction
endpackage

/* File: hdl/clk_enc_array.sv */
module clk_enc_array
   import clk_pkg::*;
(
   input wire logic clk,
   input wire logic ce,
   input wire logic wr,
   input wire logic erase,
   input wire logic [CLK_ENC_AW-1:0] waddr,
   input wire logic [7:0] wdata,
   input wire logic [CLK_ENC_AW-1:0] raddr,
   output logic [7:0] rdata
);
   // RL1 64 byte array
   // RL16 erase to ones
   logic [7:0] mem [CLK_ENC_DEPTH] = '{default: CLK_ERASED_BYTE};

   always_ff @(posedge clk) begin
      if (ce) begin
         if (erase) begin
            for (int i = 0; i < CLK_ENC_DEPTH; i++) begin
               mem[i] <= CLK_ERASED_BYTE;
            end
         end else if (wr) begin
            // Programming only clears bits
            mem[waddr] <= mem[waddr] & wdata;
         end
      end
   end

   assign rdata = mem[raddr];
endmodule

/* File: hdl/clk_code_array.sv */
module clk_code_array
   import clk_pkg::*;
(
   input wire logic clk,
   input wire logic ce,
   input wire logic wr,
   input wire logic [CLK_CODE_AW-1:0] waddr,
   input wire logic [7:0] wdata,
   input wire logic [CLK_CODE_AW-1:0] raddr,
   output logic [7:0] rdata
);
   logic [7:0] mem [CLK_CODE_DEPTH] = '{default: CLK_ERASED_BYTE};

   // Write port also serves erase, one location per cycle
   always_ff @(posedge clk) begin
      if (ce && wr) begin
         mem[waddr] <= wdata;
      end
   end

   assign rdata = mem[raddr];
endmodule

/* File: hdl/clk_lock_top.sv */
// Behaviour
// RL1 - Program memory holds a 64-byte encryption array, all ones when unprogrammed.
// RL2 - Each verify read picks an encryption byte using six address bits.
// RL3 - Verify result is code byte XNOR encryption byte.
// RL4 - Programmer should fill unused code with varied non-all-ones values.
// RL5 - Three independent lock bits select the protection level.
// RL6 - No lock bits: no restriction, verify still encrypted.
// RL7 - Level one blocks external table reads of internal code.
// RL8 - Level one latches external access select at reset only.
// RL9 - Level one refuses further code programming.
// RL10 - Level two adds disabled verify reads.
// RL11 - Level three adds blocked external execution.
// RL12 - Undefined lock combinations get no specific meaning.
// RL13 - Erasing code leaves lock bits untouched.
// RL14 - Mask variant: one lock level, table active only with it.
// RL15 - Signature read returns bytes at three signature locations.
// RL16 - Erased cells, encryption array included, read as ones.
// RL17 - Programmer gives 5 pulses per code byte, 25 otherwise.
// RL18 - Lock bits have no direct read-back.
// RL19 - Encryption index is the six low verify address bits.
// RL20 - Lock level decoded at reset, flags held until next reset.
//
// Chosen here: the register offsets and register access over Avalon-MM.
module clk_lock_top
   import clk_pkg::*;
#(
   parameter bit MASK_VARIANT = 1'b0,
   // Arbitrary neutral identity values
   parameter logic [7:0] SIG_BYTE0 = 8'hA5,
   parameter logic [7:0] SIG_BYTE1 = 8'h5A,
   parameter logic [7:0] SIG_BYTE2 = 8'h3C
)
(
   input wire logic clk,
   input wire logic rst_b,
   input wire logic ce,
   input wire logic [7:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   input wire logic external_access_select,
   output logic table_read_block,
   output logic verify_block,
   output logic ext_exec_block,
   output logic ext_access_latched
);
   // ------------------------------------------------------------
   // State
   // ------------------------------------------------------------
   typedef struct packed {
      logic ea_meta;
      logic ea_sync;
      logic decode_pend;
      logic [2:0] lock_bits;
      logic tbl_blk;
      logic vfy_blk;
      logic ext_blk;
      logic ea_latch_en;
      logic ea_latched;
      logic [CLK_CODE_AW-1:0] addr;
      logic [7:0] wdata;
      logic [2:0] cmd;
      clk_state_e state;
      logic [CLK_CODE_AW-1:0] erase_ptr;
      logic refused;
      logic [7:0] result;
      logic [31:0] rdata;
      logic waitreq;
      logic ack;
   } clk_state_s;

   // Lock bits are nonvolatile: untouched by reset
   clk_state_s st_reg = '{state: CLK_ST_IDLE, lock_bits: 3'b111, default: '0};
   clk_state_s st_next;

   logic [7:0] code_rd;
   logic [7:0] enc_rd;
   logic code_wr;
   logic [CLK_CODE_AW-1:0] code_waddr;
   logic [7:0] code_wdata;
   logic enc_wr;
   logic enc_erase;
   logic locked_any;
   clk_level_e level;

   // ------------------------------------------------------------
   // Memories
   // ------------------------------------------------------------
   clk_code_array u_code (
      .clk(clk),
      .ce(ce),
      .wr(code_wr),
      .waddr(code_waddr),
      .wdata(code_wdata),
      .raddr(st_reg.addr),
      .rdata(code_rd)
   );

   // RL19 low address bits
   clk_enc_array u_enc (
      .clk(clk),
      .ce(ce),
      .wr(enc_wr),
      .erase(enc_erase),
      .waddr(st_reg.addr[CLK_ENC_AW-1:0]),
      .wdata(st_reg.wdata),
      .raddr(st_reg.addr[CLK_ENC_AW-1:0]),
      .rdata(enc_rd)
   );

   // RL12 undefined combos fall through
   assign level = clk_decode(st_reg.lock_bits);
   assign locked_any = (st_reg.lock_bits != 3'b111);

   // ------------------------------------------------------------
   // Next state
   // ------------------------------------------------------------
   always_comb begin
      st_next = st_reg;
      code_wr = 1'b0;
      code_waddr = st_reg.addr;
      code_wdata = st_reg.wdata;
      enc_wr = 1'b0;
      enc_erase = 1'b0;
      st_next.ack = 1'b0;
      st_next.waitreq = 1'b1;

      st_next.ea_meta = external_access_select;
      st_next.ea_sync = st_reg.ea_meta;

      // RL20 decode once after reset
      if (st_reg.decode_pend) begin
         st_next.decode_pend = 1'b0;
         st_next.tbl_blk = 1'b0;
         st_next.vfy_blk = 1'b0;
         st_next.ext_blk = 1'b0;
         st_next.ea_latch_en = 1'b0;
         case (level)
            CLK_LVL_ONE: begin
               // RL7 table read block
               st_next.tbl_blk = 1'b1;
               st_next.ea_latch_en = 1'b1;
            end
            CLK_LVL_TWO: begin
               // RL10 verify disabled
               st_next.tbl_blk = 1'b1;
               st_next.ea_latch_en = 1'b1;
               st_next.vfy_blk = !MASK_VARIANT;
            end
            CLK_LVL_THREE: begin
               // RL11 external execution blocked
               st_next.tbl_blk = 1'b1;
               st_next.ea_latch_en = 1'b1;
               st_next.vfy_blk = !MASK_VARIANT;
               st_next.ext_blk = !MASK_VARIANT;
            end
            default: begin
               // RL6 nothing enabled
               st_next.tbl_blk = 1'b0;
            end
         endcase
         // RL8 sample select at reset
         st_next.ea_latched = st_reg.ea_sync;
      end else if (!st_reg.ea_latch_en) begin
         st_next.ea_latched = st_reg.ea_sync;
      end

      case (st_reg.state)
         CLK_ST_IDLE: begin
            if (!st_reg.ack && (avs_read || avs_write)) begin
               st_next.ack = 1'b1;
               st_next.waitreq = 1'b0;
               st_next.rdata = CLK_UNMAPPED_WORD;
               if (avs_write) begin
                  case (avs_address)
                     CLK_ADDR_OFS: st_next.addr = avs_writedata[CLK_CODE_AW-1:0];
                     CLK_DATA_OFS: st_next.wdata = avs_writedata[7:0];
                     CLK_CMD_OFS: begin
                        st_next.cmd = avs_writedata[2:0];
                        st_next.state = CLK_ST_EXEC;
                     end
                     default: st_next.cmd = st_reg.cmd;
                  endcase
               end else begin
                  case (avs_address)
                     CLK_ADDR_OFS: st_next.rdata = {18'h0_0000, st_reg.addr};
                     CLK_DATA_OFS: st_next.rdata = {24'h00_0000, st_reg.wdata};
                     CLK_CMD_OFS: st_next.rdata = {29'h0000_0000, st_reg.cmd};
                     // RL18 lock bits only via features
                     CLK_STAT_OFS: begin
                        st_next.rdata = CLK_RESET_WORD;
                        st_next.rdata[CLK_STAT_REFUSED_POS] = st_reg.refused;
                        st_next.rdata[CLK_STAT_TBL_BLOCK_POS] = st_reg.tbl_blk;
                        st_next.rdata[CLK_STAT_EA_LATCHED_POS] = st_reg.ea_latch_en;
                        st_next.rdata[CLK_STAT_VFY_BLOCK_POS] = st_reg.vfy_blk;
                        st_next.rdata[CLK_STAT_EXT_BLOCK_POS] = st_reg.ext_blk;
                        st_next.rdata[CLK_STAT_EA_VALUE_POS] = st_reg.ea_latched;
                     end
                     CLK_RESULT_OFS: st_next.rdata = {24'h00_0000, st_reg.result};
                     default: st_next.rdata = CLK_UNMAPPED_WORD;
                  endcase
               end
            end
         end
         CLK_ST_EXEC: begin
            st_next.state = CLK_ST_IDLE;
            st_next.refused = 1'b0;
            case (st_reg.cmd)
               CLK_CMD_PROG_CODE: begin
                  // RL9 programming refused when locked
                  if (locked_any) begin
                     st_next.refused = 1'b1;
                  end else begin
                     code_wr = 1'b1;
                     code_wdata = code_rd & st_reg.wdata;
                  end
               end
               CLK_CMD_VERIFY: begin
                  if (st_reg.vfy_blk) begin
                     st_next.refused = 1'b1;
                     st_next.result = CLK_ERASED_BYTE;
                  end else if (MASK_VARIANT && !locked_any) begin
                     // RL14 table inert without lock
                     st_next.result = code_rd;
                  end else begin
                     // RL2 RL3 encrypted verify
                     st_next.result = ~(code_rd ^ enc_rd);
                  end
               end
               CLK_CMD_PROG_ENC: begin
                  if (locked_any) begin
                     st_next.refused = 1'b1;
                  end else begin
                     enc_wr = 1'b1;
                  end
               end
               CLK_CMD_PROG_LOCK: begin
                  // RL5 independent lock bits
                  st_next.lock_bits = st_reg.lock_bits & ~st_reg.wdata[2:0];
                  if (MASK_VARIANT) begin
                     st_next.lock_bits[2:1] = 2'b11;
                  end
               end
               CLK_CMD_SIGNATURE: begin
                  // RL15 signature locations
                  if (st_reg.addr == CLK_SIG_LOC0) begin
                     st_next.result = SIG_BYTE0;
                  end else if (st_reg.addr == CLK_SIG_LOC1) begin
                     st_next.result = SIG_BYTE1;
                  end else if (st_reg.addr == CLK_SIG_LOC2) begin
                     st_next.result = SIG_BYTE2;
                  end else begin
                     st_next.result = CLK_ERASED_BYTE;
                  end
               end
               CLK_CMD_ERASE: begin
                  // RL13 lock bits survive erase
                  st_next.state = CLK_ST_ERASE;
                  st_next.erase_ptr = '0;
                  enc_erase = 1'b1;
               end
               default: st_next.refused = 1'b1;
            endcase
         end
         CLK_ST_ERASE: begin
            // RL16 cells return to ones
            code_wr = 1'b1;
            code_waddr = st_reg.erase_ptr;
            code_wdata = CLK_ERASED_BYTE;
            st_next.erase_ptr = st_reg.erase_ptr + 1'b1;
            if (&st_reg.erase_ptr) begin
               st_next.state = CLK_ST_IDLE;
            end
         end
         default: st_next.state = CLK_ST_IDLE;
      endcase
   end

   // ------------------------------------------------------------
   // Registers
   // ------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         // Synchroniser keeps running so the reset sample is the pin
         st_reg.ea_meta <= external_access_select;
         st_reg.ea_sync <= st_reg.ea_meta;
         st_reg.decode_pend <= 1'b1;
         st_reg.tbl_blk <= 1'b0;
         st_reg.vfy_blk <= 1'b0;
         st_reg.ext_blk <= 1'b0;
         st_reg.ea_latch_en <= 1'b0;
         st_reg.ea_latched <= 1'b0;
         st_reg.addr <= '0;
         st_reg.wdata <= '0;
         st_reg.cmd <= '0;
         st_reg.state <= CLK_ST_IDLE;
         st_reg.erase_ptr <= '0;
         st_reg.refused <= 1'b0;
         st_reg.result <= '0;
         st_reg.rdata <= CLK_RESET_WORD;
         st_reg.waitreq <= 1'b1;
         st_reg.ack <= 1'b0;
      end else if (ce) begin
         st_reg <= st_next;
      end
   end

   assign avs_readdata = st_reg.rdata;
   assign avs_waitrequest = st_reg.waitreq;
   assign table_read_block = st_reg.tbl_blk;
   assign verify_block = st_reg.vfy_blk;
   assign ext_exec_block = st_reg.ext_blk;
   assign ext_access_latched = st_reg.ea_latched;
endmodule

/* File: dv/clk_lock_monitor.sv */
module clk_lock_monitor
(
   input wire logic clk,
   input wire logic rst_b,
   input wire logic ce,
   input wire logic [7:0] avs_address,
   input wire logic avs_read,
   input wire logic [31:0] avs_readdata,
   input wire logic avs_waitrequest,
   input wire logic external_access_select,
   input wire logic table_read_block,
   input wire logic verify_block,
   input wire logic ext_exec_block,
   input wire logic ext_access_latched
);
   timeunit 1ns;
   timeprecision 1ps;
   // ----------------------------------------
   // Checks
   // ----------------------------------------
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_b);

   sequence s_up;
      rst_b[*5];
   endsequence
   sequence s_ea_quiet;
      ce && !table_read_block && $stable(external_access_select);
   endsequence

   property p_lvl_two;
      verify_block |-> table_read_block;
   endproperty
   a_lvl_two: assert property (p_lvl_two) else $error("verify block without table block");
   property p_lvl_three;
      ext_exec_block |-> verify_block;
   endproperty
   a_lvl_three: assert property (p_lvl_three) else $error("exec block without verify block");
   property p_flags_held;
      s_up |-> $stable({table_read_block, verify_block, ext_exec_block});
   endproperty
   a_flags_held: assert property (p_flags_held) else $error("lock flags moved");
   property p_ea_frozen;
      table_read_block && $past(table_read_block) |-> $stable(ext_access_latched);
   endproperty
   a_ea_frozen: assert property (p_ea_frozen) else $error("latched select moved");
   property p_ea_follow;
      s_ea_quiet[*6] |-> ext_access_latched == external_access_select;
   endproperty
   a_ea_follow: assert property (p_ea_follow) else $error("select not followed");
   property p_ack_one;
      !avs_waitrequest |=> avs_waitrequest;
   endproperty
   a_ack_one: assert property (p_ack_one) else $error("ack longer than one cycle");
   property p_unmapped;
      avs_read && !avs_waitrequest && avs_address > 8'h17 |-> avs_readdata == 32'h0000_0000;
   endproperty
   a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
   property p_rdata_hold;
      avs_waitrequest |-> $stable(avs_readdata);
   endproperty
   a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved");
endmodule

bind clk_lock_top clk_lock_monitor u_mon (.clk(clk), .rst_b(rst_b), .ce(ce), .avs_address(avs_address),
   .avs_read(avs_read), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
   .external_access_select(external_access_select), .table_read_block(table_read_block),
   .verify_block(verify_block), .ext_exec_block(ext_exec_block), .ext_access_latched(ext_access_latched));

/* File: dv/clk_prog_model.sv */
module clk_prog_model
   import clk_pkg::*;
(
   input wire logic clk,
   output logic [7:0] avs_address,
   output logic avs_read,
   output logic avs_write,
   output logic [31:0] avs_writedata,
   input wire logic [31:0] avs_readdata,
   input wire logic avs_waitrequest,
   output logic external_access_select
);
   timeunit 1ns;
   timeprecision 1ps;
   // ----------------------------------------
   // Programmer side
   // ----------------------------------------
   initial begin
      avs_address = 8'h00;
      avs_read = 1'b0;
      avs_write = 1'b0;
      avs_writedata = 32'h0000_0000;
      external_access_select = 1'b1;
   end

   task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
      @(posedge clk);
      avs_address <= a;
      avs_writedata <= d;
      avs_read <= !wr;
      avs_write <= wr;
      do @(posedge clk); while (avs_waitrequest !== 1'b0);
      q = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
      // Released lines never keep the last value
      avs_address <= ~a;
      avs_writedata <= ~d;
   endtask

   task automatic op(input logic [2:0] c, input logic [13:0] a, input logic [7:0] d, output logic [31:0] st);
      logic [31:0] q;
      xfer(1'b1, CLK_ADDR_OFS, {18'h0_0000, a}, q);
      xfer(1'b1, CLK_DATA_OFS, {24'h00_0000, d}, q);
      xfer(1'b1, CLK_CMD_OFS, {29'h0000_0000, c}, q);
      st = 32'h0000_0001;
      while (st[CLK_STAT_BUSY_POS] !== 1'b0) xfer(1'b0, CLK_STAT_OFS, 32'h0000_0000, st);
   endtask

   task automatic burn(input logic [2:0] c, input logic [13:0] a, input logic [7:0] d, output logic [31:0] st);
      repeat ((c == CLK_CMD_PROG_CODE) ? 5 : 25) op(c, a, d, st);
   endtask

   task automatic set_ea(input logic v);
      @(posedge clk);
      external_access_select <= v;
   endtask
endmodule

/* File: dv/clk_lock_top_tb.sv */
module clk_lock_top_tb
   import clk_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   // Arbitrary signature values
   localparam logic [7:0] SIG0 = 8'h1E;
   localparam logic [7:0] SIG1 = 8'h2D;
   localparam logic [7:0] SIG2 = 8'h4B;
   logic clk, rst_b, ce, rd, wr, wait_n, ea, tbl, vfy, ext, eal;
   logic [7:0] addr;
   logic [31:0] wdata, rdata, st;
   logic [13:0] sl [3];
   logic [7:0] sb [3];
   int err_count, check_count, cyc;

   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end

   clk_lock_top #(.MASK_VARIANT(1'b0), .SIG_BYTE0(SIG0), .SIG_BYTE1(SIG1), .SIG_BYTE2(SIG2)) DUT (
      .clk(clk), .rst_b(rst_b), .ce(ce), .avs_address(addr), .avs_read(rd), .avs_write(wr),
      .avs_writedata(wdata), .avs_readdata(rdata), .avs_waitrequest(wait_n), .external_access_select(ea),
      .table_read_block(tbl), .verify_block(vfy), .ext_exec_block(ext), .ext_access_latched(eal));

   clk_prog_model prog (.clk(clk), .avs_address(addr), .avs_read(rd), .avs_write(wr), .avs_writedata(wdata),
      .avs_readdata(rdata), .avs_waitrequest(wait_n), .external_access_select(ea));

   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   task chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         err_count++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task chk_lvl(input logic [2:0] e);
      chk({29'h0000_0000, tbl, vfy, ext}, {29'h0000_0000, e});
   endtask

   task res(input logic [2:0] c, input logic [13:0] a, input logic [7:0] e);
      prog.op(c, a, 8'h00, st);
      prog.xfer(1'b0, CLK_RESULT_OFS, 32'h0000_0000, st);
      chk(st, {24'h00_0000, e});
   endtask

   task reboot;
      @(posedge clk);
      rst_b <= 1'b0;
      repeat (4) @(posedge clk);
      rst_b <= 1'b1;
      repeat (3) @(posedge clk);
   endtask

   task print_verdict;
      if (err_count == 0 && check_count > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 60000) begin
         err_count++;
         print_verdict;
      end
   end

   // ----------------------------------------
   // Tests
   // ----------------------------------------
   initial begin
      rst_b = 1'b0;
      ce = 1'b1;
      err_count = 0;
      check_count = 0;
      cyc = 0;
      sl = '{CLK_SIG_LOC0, CLK_SIG_LOC1, CLK_SIG_LOC2};
      sb = '{SIG0, SIG1, SIG2};
      repeat (4) @(posedge clk);
      rst_b <= 1'b1;
      repeat (3) @(posedge clk);
      chk_lvl(3'h0);
      prog.burn(CLK_CMD_PROG_CODE, 14'h0041, 8'h5A, st);
      chk(st & 32'h0000_0002, 32'h0000_0000);
      prog.burn(CLK_CMD_PROG_ENC, 14'h0001, 8'h0F, st);
      res(CLK_CMD_VERIFY, 14'h0041, 8'hAA);
      res(CLK_CMD_VERIFY, 14'h0001, 8'h0F);
      res(CLK_CMD_VERIFY, 14'h0042, 8'hFF);
      for (int i = 0; i < 3; i++) res(CLK_CMD_SIGNATURE, sl[i], sb[i]);
      prog.xfer(1'b0, 8'h40, 32'h0000_0000, st);
      chk(st, 32'h0000_0000);
      prog.set_ea(1'b0);
      repeat (6) @(posedge clk);
      chk({31'h0000_0000, eal}, 32'h0000_0000);
      // Clock enable low freezes the synchroniser
      ce <= 1'b0;
      prog.set_ea(1'b1);
      repeat (6) @(posedge clk);
      chk({31'h0000_0000, eal}, 32'h0000_0000);
      ce <= 1'b1;
      repeat (6) @(posedge clk);
      chk({31'h0000_0000, eal}, 32'h0000_0001);
      // Lock bits go in one at a time, in level order
      prog.burn(CLK_CMD_PROG_LOCK, 14'h0000, 8'h01, st);
      reboot;
      chk_lvl(3'h4);
      prog.set_ea(1'b0);
      repeat (6) @(posedge clk);
      chk({31'h0000_0000, eal}, 32'h0000_0001);
      prog.op(CLK_CMD_PROG_CODE, 14'h0041, 8'h00, st);
      chk(st & 32'h0000_0002, 32'h0000_0002);
      res(CLK_CMD_VERIFY, 14'h0041, 8'hAA);
      prog.burn(CLK_CMD_PROG_LOCK, 14'h0000, 8'h02, st);
      reboot;
      chk_lvl(3'h6);
      chk({31'h0000_0000, eal}, 32'h0000_0000);
      prog.op(CLK_CMD_VERIFY, 14'h0041, 8'h00, st);
      chk(st & 32'h0000_0002, 32'h0000_0002);
      prog.xfer(1'b0, CLK_RESULT_OFS, 32'h0000_0000, st);
      chk(st, 32'h0000_00FF);
      prog.burn(CLK_CMD_PROG_LOCK, 14'h0000, 8'h04, st);
      reboot;
      chk_lvl(3'h7);
      prog.op(CLK_CMD_ERASE, 14'h0000, 8'h00, st);
      reboot;
      chk_lvl(3'h7);
      prog.op(CLK_CMD_PROG_CODE, 14'h0041, 8'h00, st);
      chk(st & 32'h0000_0002, 32'h0000_0002);
      print_verdict;
   end
endmodule
